//--- core/psc_cache.sv
// Primary split cache: instruction and data caches with one shared refill and write-buffer port.
// Assumes the pipeline and memory side run on clk; requests are levels held until acknowledged.
//
// Overview of operation
// - Separate instruction and data caches, own paths.
// - Line is eight 32-bit words, one tag.
// - Miss loads whole line from memory, except a write-through store miss.
// - Hit returns data without memory access.
// - Virtual index selects set, physical tag compares.
// - Instruction cache two-way, 32-byte lines.
// - Instruction tag: address, valid, reserved, parity, FIFO.
// - Instruction data carries parity per word.
// - Data tag: address, state, modified, parities, FIFO.
// - Per-page write-back or write-through, two-way.
// - Write-back stores stay in cache until replacement.
// - Write-through stores also go to memory.
// - Data miss restarts pipeline on first doubleword.
// - State codes: invalid, shared, clean, dirty exclusive.
// - Physical tag holds address bits 35 to 12.
// - Data cache has even parity per byte.
// - Modified flag decides write-back on replacement.
`timescale 1ns/100ps
module psc_cache
(
  input wire logic clk,
  input wire logic rst,
  input wire logic i_req,
  input wire logic [psc_pkg::VA_W-1:0] i_vaddr,
  input wire logic [psc_pkg::PA_W-1:0] i_paddr,
  output logic i_ready,
  output logic i_ack,
  output logic [63:0] i_rdata,
  output logic i_par_err,
  input wire logic d_req,
  input wire logic d_store,
  input wire logic [7:0] d_byte_en,
  input wire logic d_write_through,
  input wire logic [psc_pkg::VA_W-1:0] d_vaddr,
  input wire logic [psc_pkg::PA_W-1:0] d_paddr,
  input wire logic [63:0] d_wdata,
  output logic d_ready,
  output logic d_ack,
  output logic [63:0] d_rdata,
  output logic d_par_err,
  output logic mem_rd_req,
  output logic [psc_pkg::PA_W-1:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [63:0] mem_rd_data,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [psc_pkg::PA_W-1:0] mem_wr_addr,
  output logic [63:0] mem_wr_data,
  output logic [7:0] mem_wr_be
);
  function automatic logic [7:0] byte_par(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

  // Data cache: one even parity bit per byte; instruction cache: one per 32-bit word.
  function automatic logic [71:0] with_par(input logic dc, input logic [63:0] d);
    return dc ? {byte_par(d), d} : {6'h00, ^d[63:32], ^d[31:0], d};
  endfunction

  function automatic logic [63:0] merge(input logic [63:0] o, input logic [63:0] n, input logic [7:0] be);
    logic [63:0] r;
    r = o;
    for (int i = 0; i < 8; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_hit(input logic dc, input logic [29:0] t, input logic [23:0] pt);
    logic ok;
    ok = dc ? (t[psc_pkg::DTAG_CS +: 2] != psc_pkg::PSC_CS_INVALID) : t[psc_pkg::ITAG_V];
    return ok && (t[psc_pkg::PHYSICAL_TAG_FIELD_W-1:0] == pt);
  endfunction

  function automatic logic fbit(input logic dc, input logic [29:0] t);
    return dc ? t[psc_pkg::DTAG_F] : t[psc_pkg::ITAG_F];
  endfunction

  function automatic logic [29:0] set_f(input logic dc, input logic [29:0] t, input logic f);
    logic [29:0] r;
    r = t;
    if (dc)
    begin
      r[psc_pkg::DTAG_F] = f;
    end
    else
    begin
      r[psc_pkg::ITAG_F] = f;
    end
    return r;
  endfunction

  // A filled data line enters dirty exclusive; the modified flag alone marks it as written.
  function automatic logic [29:0] new_tag(input logic dc, input logic f, input logic w, input logic [23:0] pt);
    logic [29:0] r;
    r = 30'h0000_0000;
    r[psc_pkg::PHYSICAL_TAG_FIELD_W-1:0] = pt;
    if (dc)
    begin
      r[psc_pkg::DTAG_CS +: 2] = psc_pkg::PSC_CS_DIRTY_EXCL;
      r[psc_pkg::DTAG_P] = ^{psc_pkg::PSC_CS_DIRTY_EXCL, pt};
      r[psc_pkg::DTAG_WB] = w;
      r[psc_pkg::DTAG_WBP] = w;
      r[psc_pkg::DTAG_F] = f;
    end
    else
    begin
      r[psc_pkg::ITAG_V] = 1'b1;
      r[psc_pkg::ITAG_P] = ^{1'b1, pt};
      r[psc_pkg::ITAG_F] = f;
    end
    return r;
  endfunction

  psc_pkg::psc_state_t state_r, state_nxt;
  logic sel_d_r, sel_d_nxt, store_r, store_nxt, wt_r, wt_nxt, victim_r, victim_nxt;
  logic [psc_pkg::SET_W-1:0] idx_r, idx_nxt, cnt_r, cnt_nxt;
  logic [psc_pkg::DW_W-1:0] dw_r, dw_nxt;
  logic [psc_pkg::LINE_W-1:0] line_r, line_nxt;
  logic [7:0] be_r, be_nxt, mem_wr_be_nxt;
  logic [63:0] wdata_r, wdata_nxt, i_rdata_nxt, d_rdata_nxt, mem_wr_data_nxt;
  logic i_ready_nxt, i_ack_nxt, i_par_err_nxt, d_ready_nxt, d_ack_nxt, d_par_err_nxt;
  logic mem_rd_req_nxt, mem_wr_valid_nxt;
  logic [psc_pkg::PA_W-1:0] mem_rd_addr_nxt, mem_wr_addr_nxt;
  logic [29:0] tag_rd [4];
  logic [71:0] data_rd [4];
  logic [29:0] tag_wd [2];
  logic [3:0] tag_we, data_we;
  logic [71:0] data_wd;
  logic [psc_pkg::SET_W-1:0] tag_addr;
  logic [psc_pkg::SET_W+psc_pkg::DW_W-1:0] data_addr;
  logic [1:0] hit_w;
  logic hit, hway, vic, take_d, take_i;
  logic [23:0] physical_tag_field;
  logic [71:0] hq;
  logic [63:0] fill_word;
  logic [psc_pkg::DW_W-1:0] beat;

  // Arrays 0 and 1 are instruction ways, 2 and 3 data ways; no array is shared.
  for (genvar g = 0; g < 4; g++)
  begin : g_way
    localparam int TW = (g >= 2) ? psc_pkg::DTAG_W : psc_pkg::ITAG_W;
    localparam int DWD = (g >= 2) ? psc_pkg::DDATA_W : psc_pkg::IDATA_W;
    logic [TW-1:0] trd;
    logic [DWD-1:0] drd;
    psc_ram #(.WIDTH(TW), .DEPTH(psc_pkg::SETS), .AW(psc_pkg::SET_W)) u_tag
    (
      .clk(clk),
      .we(tag_we[g]),
      .addr(tag_addr),
      .wdata(tag_wd[g % 2][TW-1:0]),
      .rdata(trd)
    );
    // Each entry holds one doubleword, four entries per eight-word line.
    psc_ram #(.WIDTH(DWD), .DEPTH(psc_pkg::SETS * psc_pkg::DWORDS_PER_LINE), .AW(10)) u_data
    (
      .clk(clk),
      .we(data_we[g]),
      .addr(data_addr),
      .wdata(data_wd[DWD-1:0]),
      .rdata(drd)
    );
    assign tag_rd[g] = 30'(trd);
    assign data_rd[g] = 72'(drd);
  end

  assign physical_tag_field = line_r[psc_pkg::LINE_W-1:psc_pkg::PHYSICAL_TAG_FIELD_LSB_IN_LINE];
  assign beat = cnt_r[psc_pkg::DW_W-1:0];
  assign take_d = d_req && d_ready;
  assign take_i = i_req && i_ready && !take_d;

  always_comb
  begin
    for (int w = 0; w < 2; w++)
    begin
      hit_w[w] = is_hit(sel_d_r, tag_rd[{sel_d_r, 1'(w)}], physical_tag_field);
    end
    hit = |hit_w;
    hway = hit_w[1];
    hq = data_rd[{sel_d_r, hway}];
    vic = fbit(sel_d_r, tag_rd[{sel_d_r, 1'b0}]);
    fill_word = (beat == 2'h0 && store_r) ? merge(mem_rd_data, wdata_r, be_r) : mem_rd_data;
  end

  always_comb
  begin
    state_nxt = state_r;
    sel_d_nxt = sel_d_r;
    store_nxt = store_r;
    wt_nxt = wt_r;
    victim_nxt = victim_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    dw_nxt = dw_r;
    line_nxt = line_r;
    be_nxt = be_r;
    wdata_nxt = wdata_r;
    i_rdata_nxt = i_rdata;
    d_rdata_nxt = d_rdata;
    i_par_err_nxt = i_par_err;
    d_par_err_nxt = d_par_err;
    i_ack_nxt = 1'b0;
    d_ack_nxt = 1'b0;
    mem_rd_req_nxt = 1'b0;
    mem_rd_addr_nxt = mem_rd_addr;
    mem_wr_valid_nxt = mem_wr_valid;
    mem_wr_addr_nxt = mem_wr_addr;
    mem_wr_data_nxt = mem_wr_data;
    mem_wr_be_nxt = mem_wr_be;
    tag_we = 4'h0;
    data_we = 4'h0;
    tag_addr = idx_r;
    data_addr = {idx_r, dw_r};
    tag_wd[0] = tag_rd[{sel_d_r, 1'b0}];
    tag_wd[1] = tag_rd[{sel_d_r, 1'b1}];
    data_wd = 72'h00_0000_0000_0000_0000;
    case (state_r)
      psc_pkg::ST_INIT:
      begin
        // Tag arrays power up unknown, so every set is cleared before the first lookup.
        tag_addr = cnt_r;
        tag_we = 4'hf;
        tag_wd[0] = 30'h0000_0000;
        tag_wd[1] = 30'h0000_0000;
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == psc_pkg::INIT_LAST)
        begin
          state_nxt = psc_pkg::ST_IDLE;
        end
      end
      psc_pkg::ST_IDLE:
      begin
        if (take_d || take_i)
        begin
          sel_d_nxt = take_d;
          store_nxt = take_d && d_store;
          wt_nxt = d_write_through;
          be_nxt = d_byte_en;
          wdata_nxt = d_wdata;
          idx_nxt = take_d ? d_vaddr[12:5] : i_vaddr[12:5];
          dw_nxt = take_d ? d_vaddr[4:3] : i_vaddr[4:3];
          line_nxt = take_d ? d_paddr[35:5] : i_paddr[35:5];
          tag_addr = idx_nxt;
          data_addr = {idx_nxt, dw_nxt};
          state_nxt = psc_pkg::ST_CMP;
        end
      end
      psc_pkg::ST_CMP:
      begin
        cnt_nxt = psc_pkg::RST_CNT;
        if (hit && !store_r)
        begin
          i_rdata_nxt = sel_d_r ? i_rdata : hq[63:0];
          d_rdata_nxt = sel_d_r ? hq[63:0] : d_rdata;
          i_par_err_nxt = sel_d_r ? i_par_err : par_bad(1'b0, hq);
          d_par_err_nxt = sel_d_r ? par_bad(1'b1, hq) : d_par_err;
          i_ack_nxt = !sel_d_r;
          d_ack_nxt = sel_d_r;
          state_nxt = psc_pkg::ST_IDLE;
        end
        else if (hit)
        begin
          data_we[{1'b1, hway}] = 1'b1;
          data_wd = with_par(1'b1, merge(hq[63:0], wdata_r, be_r));
          d_ack_nxt = 1'b1;
          if (!wt_r)
          begin
            tag_we[{1'b1, hway}] = 1'b1;
            tag_wd[hway] = new_tag(1'b1, fbit(1'b1, tag_rd[{1'b1, hway}]), 1'b1, physical_tag_field);
            state_nxt = psc_pkg::ST_IDLE;
          end
          else
          begin
            // The modified flag stays as it was; the store goes out through the write buffer.
            mem_wr_valid_nxt = 1'b1;
            state_nxt = psc_pkg::ST_POST;
          end
        end
        else if (store_r && wt_r)
        begin
          mem_wr_valid_nxt = 1'b1;
          d_ack_nxt = 1'b1;
          state_nxt = psc_pkg::ST_POST;
        end
        else
        begin
          victim_nxt = vic;
          state_nxt = (sel_d_r && tag_rd[{1'b1, vic}][psc_pkg::DTAG_WB]) ? psc_pkg::ST_WB_RD : psc_pkg::ST_FILL_REQ;
        end
        mem_wr_addr_nxt = {line_r, dw_r, 3'h0};
        mem_wr_data_nxt = wdata_r;
        mem_wr_be_nxt = be_r;
      end
      psc_pkg::ST_WB_RD:
      begin
        data_addr = {idx_r, beat};
        state_nxt = psc_pkg::ST_WB_SEND;
      end
      psc_pkg::ST_WB_SEND:
      begin
        data_addr = {idx_r, beat};
        if (!mem_wr_valid)
        begin
          mem_wr_valid_nxt = 1'b1;
          mem_wr_addr_nxt = {tag_rd[{1'b1, victim_r}][23:0], idx_r[6:0], beat, 3'h0};
          mem_wr_data_nxt = data_rd[{1'b1, victim_r}][63:0];
          mem_wr_be_nxt = 8'hff;
        end
        else if (mem_wr_ready)
        begin
          mem_wr_valid_nxt = 1'b0;
          cnt_nxt = (beat == psc_pkg::LAST_BEAT) ? psc_pkg::RST_CNT : cnt_r + 8'h01;
          state_nxt = (beat == psc_pkg::LAST_BEAT) ? psc_pkg::ST_FILL_REQ : psc_pkg::ST_WB_RD;
        end
      end
      psc_pkg::ST_FILL_REQ:
      begin
        mem_rd_req_nxt = 1'b1;
        mem_rd_addr_nxt = {line_r, dw_r, 3'h0};
        state_nxt = psc_pkg::ST_FILL;
      end
      psc_pkg::ST_FILL:
      begin
        data_addr = {idx_r, dw_r + beat};
        if (mem_rd_valid)
        begin
          data_we[{sel_d_r, victim_r}] = 1'b1;
          data_wd = with_par(sel_d_r, fill_word);
          cnt_nxt = cnt_r + 8'h01;
          if (beat == 2'h0)
          begin
            // Critical doubleword first: the data side restarts while the rest streams in.
            d_ack_nxt = sel_d_r;
            d_rdata_nxt = sel_d_r ? mem_rd_data : d_rdata;
            d_par_err_nxt = sel_d_r ? 1'b0 : d_par_err;
            i_rdata_nxt = sel_d_r ? i_rdata : mem_rd_data;
            i_par_err_nxt = sel_d_r ? i_par_err : 1'b0;
          end
          if (beat == psc_pkg::LAST_BEAT)
          begin
            tag_we[{sel_d_r, 1'b0}] = 1'b1;
            tag_we[{sel_d_r, 1'b1}] = 1'b1;
            tag_wd[victim_r] = new_tag(sel_d_r, !victim_r, store_r, physical_tag_field);
            tag_wd[!victim_r] = set_f(sel_d_r, tag_rd[{sel_d_r, !victim_r}], !victim_r);
            i_ack_nxt = !sel_d_r;
            state_nxt = psc_pkg::ST_IDLE;
          end
        end
      end
      psc_pkg::ST_POST:
      begin
        if (mem_wr_ready)
        begin
          mem_wr_valid_nxt = 1'b0;
          state_nxt = psc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = psc_pkg::ST_INIT;
      end
    endcase
    i_ready_nxt = (state_nxt == psc_pkg::ST_IDLE) && !i_ack_nxt;
    d_ready_nxt = (state_nxt == psc_pkg::ST_IDLE) && !d_ack_nxt;
  end

  function automatic logic par_bad(input logic dc, input logic [71:0] q);
    return q != with_par(dc, q[63:0]);
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= psc_pkg::ST_INIT;
      {sel_d_r, store_r, wt_r, victim_r} <= 4'h0;
      idx_r <= 8'h00;
      cnt_r <= psc_pkg::RST_CNT;
      dw_r <= 2'h0;
      line_r <= 31'h0000_0000;
      be_r <= 8'h00;
      wdata_r <= 64'h0000_0000_0000_0000;
      {i_ready, i_ack, i_par_err, d_ready, d_ack, d_par_err} <= 6'h00;
      i_rdata <= 64'h0000_0000_0000_0000;
      d_rdata <= 64'h0000_0000_0000_0000;
      {mem_rd_req, mem_wr_valid} <= 2'h0;
      mem_rd_addr <= 36'h0_0000_0000;
      mem_wr_addr <= 36'h0_0000_0000;
      mem_wr_data <= 64'h0000_0000_0000_0000;
      mem_wr_be <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      {sel_d_r, store_r, wt_r, victim_r} <= {sel_d_nxt, store_nxt, wt_nxt, victim_nxt};
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      dw_r <= dw_nxt;
      line_r <= line_nxt;
      be_r <= be_nxt;
      wdata_r <= wdata_nxt;
      {i_ready, i_ack, i_par_err} <= {i_ready_nxt, i_ack_nxt, i_par_err_nxt};
      {d_ready, d_ack, d_par_err} <= {d_ready_nxt, d_ack_nxt, d_par_err_nxt};
      i_rdata <= i_rdata_nxt;
      d_rdata <= d_rdata_nxt;
      {mem_rd_req, mem_wr_valid} <= {mem_rd_req_nxt, mem_wr_valid_nxt};
      mem_rd_addr <= mem_rd_addr_nxt;
      mem_wr_addr <= mem_wr_addr_nxt;
      mem_wr_data <= mem_wr_data_nxt;
      mem_wr_be <= mem_wr_be_nxt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_one_side_ack: assert property (!(i_ack && d_ack)) else $error("both caches acknowledged at once");
  a_fill_last_beat: assert property (state_r == psc_pkg::ST_FILL && mem_rd_valid && beat == psc_pkg::LAST_BEAT
    |=> state_r == psc_pkg::ST_IDLE && !mem_rd_req) else $error("fill did not end after four doublewords");
  a_miss_fetch: assert property (state_r == psc_pkg::ST_CMP && !hit && !store_r && !(sel_d_r && tag_rd[{1'b1, vic}][psc_pkg::DTAG_WB])
    |-> ##2 mem_rd_req && mem_rd_addr == {line_r, dw_r, 3'h0}) else $error("miss did not request its line");
  a_hit_load: assert property (state_r == psc_pkg::ST_CMP && hit && !store_r
    |=> (sel_d_r ? d_ack : i_ack) && !mem_rd_req && !mem_wr_valid) else $error("hit not served from cache");
  a_wb_store_local: assert property (state_r == psc_pkg::ST_CMP && hit && store_r && !wt_r
    |=> d_ack && !mem_wr_valid ##1 !mem_wr_valid) else $error("write-back store reached memory");
  a_wt_store_post: assert property (state_r == psc_pkg::ST_CMP && store_r && wt_r
    |=> mem_wr_valid && d_ack && mem_wr_data == $past(wdata_r)) else $error("write-through store not posted");
  a_early_restart: assert property (state_r == psc_pkg::ST_FILL && mem_rd_valid && beat == 2'h0 && sel_d_r
    |=> d_ack && d_rdata == $past(mem_rd_data) && state_r == psc_pkg::ST_FILL) else $error("no early restart");
  a_data_parity: assert property (|data_we[3:2] |-> data_wd[71:64] == byte_par(data_wd[63:0]))
    else $error("data cache byte parity wrong");
  a_dirty_victim: assert property (state_r == psc_pkg::ST_CMP && !hit && sel_d_r && !(store_r && wt_r)
    && tag_rd[{1'b1, vic}][psc_pkg::DTAG_WB] |=> state_r == psc_pkg::ST_WB_RD) else $error("dirty victim skipped");
  a_fifo_toggle: assert property (state_r == psc_pkg::ST_FILL && mem_rd_valid && beat == psc_pkg::LAST_BEAT
    |-> fbit(sel_d_r, tag_wd[0]) == !victim_r && fbit(sel_d_r, tag_wd[1]) == !victim_r) else $error("FIFO bit not toggled");

  c_data_hit: cover property (state_r == psc_pkg::ST_CMP && hit && sel_d_r);
  c_write_back: cover property (state_r == psc_pkg::ST_WB_SEND && mem_wr_valid && mem_wr_ready);
  c_early_ack: cover property (d_ack && state_r == psc_pkg::ST_FILL);
  c_inst_fill: cover property (i_ack && $past(state_r) == psc_pkg::ST_FILL);
endmodule

//--- core/psc_pkg.sv
// Shared constants and types of the primary split cache.
// Assumes a 36-bit physical and 13-bit virtual index address and 64-bit doubleword transfers.
package psc_pkg;
  localparam int PA_W = 36;
  localparam int VA_W = 13;
  localparam int SET_W = 8;
  localparam int SETS = 256;
  localparam int DW_W = 2;
  localparam int DWORDS_PER_LINE = 4;
  localparam int WORDS_PER_LINE = 8;
  localparam int IDX_LSB = 5;
  localparam int DW_LSB = 3;
  localparam int LINE_W = 31;
  localparam int PHYSICAL_TAG_FIELD_W = 24;
  localparam int PHYSICAL_TAG_FIELD_LSB_IN_LINE = 7;
  localparam int ITAG_W = 28;
  localparam int DTAG_W = 30;
  localparam int TAG_RAM_W = 30;
  localparam int IDATA_W = 66;
  localparam int DDATA_W = 72;
  localparam int DATA_RAM_W = 72;
  localparam int ITAG_V = 24;
  localparam int ITAG_RSV = 25;
  localparam int ITAG_P = 26;
  localparam int ITAG_F = 27;
  localparam int DTAG_CS = 24;
  localparam int DTAG_P = 26;
  localparam int DTAG_WB = 27;
  localparam int DTAG_WBP = 28;
  localparam int DTAG_F = 29;
  localparam logic [SET_W-1:0] INIT_LAST = 8'hff;
  localparam logic [DW_W-1:0] LAST_BEAT = 2'h3;
  localparam logic [7:0] RST_CNT = 8'h00;

  typedef enum logic [1:0]
  {
    PSC_CS_INVALID = 2'h0,
    PSC_CS_SHARED = 2'h1,
    PSC_CS_CLEAN_EXCL = 2'h2,
    PSC_CS_DIRTY_EXCL = 2'h3
  } psc_cs_t;

  typedef enum logic [7:0]
  {
    ST_INIT = 8'h01,
    ST_IDLE = 8'h02,
    ST_CMP = 8'h04,
    ST_WB_RD = 8'h08,
    ST_WB_SEND = 8'h10,
    ST_FILL_REQ = 8'h20,
    ST_FILL = 8'h40,
    ST_POST = 8'h80
  } psc_state_t;
endpackage

//--- core/psc_ram.sv
// Single-port synchronous array used for cache tags and cache data.
// Read data come out of a register one clock after the address; contents are not reset.
`timescale 1ns/100ps
module psc_ram
#(
  parameter int WIDTH = 72,
  parameter int DEPTH = 1024,
  parameter int AW = 10
)
(
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // A write returns the old contents in the same cycle.
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- verification/psc_cache_test.sv
// Self-checking bench of the primary split cache against a memory-image model.
// Assumes psc_pkg is compiled first and the memory model stands on the far side.
`timescale 1ns/100ps
module psc_cache_test;
  logic clk, rst, slow, i_req, i_ready, i_ack, i_par_err, d_req, d_store, d_write_through;
  logic d_ready, d_ack, d_par_err, mem_rd_req, mem_rd_valid, mem_wr_valid, mem_wr_ready;
  logic [12:0] i_vaddr, d_vaddr;
  logic [35:0] i_paddr, d_paddr, mem_rd_addr, mem_wr_addr, a, c, d, e;
  logic [63:0] i_rdata, d_wdata, d_rdata, mem_rd_data, mem_wr_data;
  logic [7:0] d_byte_en, mem_wr_be;
  logic [63:0] ref_mem [logic [32:0]];
  int n_rd, n_wr, n_beat, nb, r0, w0, n_mismatch, n_checks, cyc;

  psc_cache psc_cache_i (.clk, .rst, .i_req, .i_vaddr, .i_paddr, .i_ready, .i_ack, .i_rdata, .i_par_err,
    .d_req, .d_store, .d_byte_en, .d_write_through, .d_vaddr, .d_paddr, .d_wdata, .d_ready, .d_ack,
    .d_rdata, .d_par_err, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .mem_wr_valid,
    .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_wr_be);
  psc_mem_model psc_mem_model_i (.clk, .slow, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
    .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_wr_be, .n_rd, .n_wr, .n_beat);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [63:0] expv(logic [35:0] p);
    return ref_mem.exists(p[35:3]) ? ref_mem[p[35:3]] : {p[34:3] ^ 32'h5a5a_0f0f, ~p[34:3]};
  endfunction

  task automatic chk(string what, logic [63:0] x, logic [63:0] got);
    n_checks++;
    if (got !== x)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, x, got);
    end
  endtask

  task automatic dacc(logic st, logic wt, logic [35:0] pa, logic [63:0] wd, logic [7:0] be);
    logic [63:0] x;
    int k;
    x = expv(pa);
    for (k = 0; k < 8; k++)
      if (st && be[k])
        x[8*k +: 8] = wd[8*k +: 8];
    if (st)
      ref_mem[pa[35:3]] = x;
    d_req <= 1'b1;
    d_store <= st;
    d_write_through <= wt;
    d_paddr <= pa;
    d_vaddr <= pa[12:0];
    d_wdata <= wd;
    d_byte_en <= be;
    for (k = 0; k < 600 && d_ack !== 1'b1; k++)
      @(posedge clk);
    // A wait that runs out counts as a mismatch, so stale read data cannot pass.
    chk("data ack", 64'h1, 64'(d_ack));
    nb = n_beat;
    if (!st)
      chk("load data", x, d_rdata);
    chk("data parity", 64'h0, 64'(d_par_err));
    d_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic iacc(logic [35:0] pa);
    int k;
    i_req <= 1'b1;
    i_paddr <= pa;
    i_vaddr <= pa[12:0];
    for (k = 0; k < 600 && i_ack !== 1'b1; k++)
      @(posedge clk);
    chk("fetch ack", 64'h1, 64'(i_ack));
    nb = n_beat;
    chk("fetch data", expv(pa), i_rdata);
    chk("fetch parity", 64'h0, 64'(i_par_err));
    i_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cnt(string what, int x, int got);
    chk(what, 64'(x), 64'(got));
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    {i_req, d_req, d_store, d_write_through, d_byte_en, slow, n_mismatch, n_checks, cyc} = '0;
    {i_vaddr, d_vaddr, i_paddr, d_paddr, d_wdata} = '0;
    rst = 1'b1;
    void'($urandom(32'h0b14));
    // Tags differ only above bit 12, so all four lines share one set.
    a = 36'ha1b_2c40_48;
    c = 36'h000_0060_48;
    d = 36'hfff_ff80_48;
    e = 36'h5a5_a5a0_48;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    slow <= 1'b1;
    r0 = n_rd;
    dacc(0, 0, a, 0, 0);
    cnt("refills", r0 + 1, n_rd);
    cnt("beats at ack", 1, nb);
    dacc(0, 0, a, 0, 0);
    dacc(0, 0, a + 36'h8, 0, 0);
    dacc(0, 0, a - 36'h8, 0, 0);
    cnt("refills", r0 + 1, n_rd);
    iacc(36'h7e0_0021_a0);
    cnt("beats at fetch ack", 4, nb);
    iacc(36'h7e0_0021_b8);
    cnt("refills", r0 + 2, n_rd);
    $display("test miss_hit done");
    w0 = n_wr;
    dacc(1, 0, a, {$urandom, $urandom}, 8'h5a);
    dacc(0, 0, a, 0, 0);
    cnt("writes", w0, n_wr);
    dacc(1, 1, a + 36'h8, {$urandom, $urandom}, 8'hff);
    for (int k = 0; k < 40 && n_wr == w0; k++)
      @(posedge clk);
    cnt("writes", w0 + 1, n_wr);
    dacc(0, 0, a + 36'h8, 0, 0);
    $display("test stores done");
    slow <= 1'b0;
    r0 = n_rd;
    w0 = n_wr;
    dacc(0, 0, c, 0, 0);
    dacc(0, 0, a, 0, 0);
    cnt("refills", r0 + 1, n_rd);
    dacc(0, 0, d, 0, 0);
    cnt("victim writes", w0 + 4, n_wr);
    dacc(0, 0, c, 0, 0);
    cnt("refills", r0 + 2, n_rd);
    dacc(0, 0, e, 0, 0);
    cnt("clean victim writes", w0 + 4, n_wr);
    dacc(0, 0, a, 0, 0);
    cnt("refills", r0 + 4, n_rd);
    $display("test evict done");
    for (int k = 0; k < 150; k++)
    begin
      int op;
      op = $urandom_range(2);
      slow <= 1'($urandom_range(1));
      dacc(op != 0, op == 2, {2'($urandom_range(3)), 22'h15_5554, 6'h02, 1'($urandom_range(1)),
        2'($urandom_range(3)), 3'h0}, {$urandom, $urandom}, 8'($urandom_range(255, 1)));
    end
    $display("test random done");
    finish_test();
  end
endmodule

//--- verification/psc_mem_model.sv
// Behavioural main memory on the refill and write-buffer ports of the cache.
// Assumes one refill outstanding at a time; slow adds fixed gaps on both ports.
`timescale 1ns/100ps
module psc_mem_model
(
  input wire logic clk,
  input wire logic slow,
  input wire logic mem_rd_req,
  input wire logic [35:0] mem_rd_addr,
  output logic mem_rd_valid,
  output logic [63:0] mem_rd_data,
  input wire logic mem_wr_valid,
  output logic mem_wr_ready,
  input wire logic [35:0] mem_wr_addr,
  input wire logic [63:0] mem_wr_data,
  input wire logic [7:0] mem_wr_be,
  output int n_rd,
  output int n_wr,
  output int n_beat
);
  logic [63:0] mem [logic [32:0]];
  logic [32:0] cur;
  logic [1:0] g;
  int left;

  function automatic logic [63:0] dflt(logic [32:0] a);
    return {a[31:0] ^ 32'h5a5a_0f0f, ~a[31:0]};
  endfunction

  initial
  begin
    {mem_rd_valid, mem_wr_ready, g, left, n_rd, n_wr, n_beat} = '0;
    mem_rd_data = 64'h0000_0000_0000_0000;
  end

  always @(posedge clk)
  begin
    logic [63:0] w;
    g <= g + 2'h1;
    mem_rd_valid <= 1'b0;
    // A released data bus must not keep showing the last beat.
    mem_rd_data <= ~mem_rd_data;
    mem_wr_ready <= !slow || g[0];
    if (mem_wr_valid && mem_wr_ready)
    begin
      w = mem.exists(mem_wr_addr[35:3]) ? mem[mem_wr_addr[35:3]] : dflt(mem_wr_addr[35:3]);
      for (int b = 0; b < 8; b++)
        if (mem_wr_be[b])
          w[8*b +: 8] = mem_wr_data[8*b +: 8];
      mem[mem_wr_addr[35:3]] = w;
      n_wr <= n_wr + 1;
    end
    if (mem_rd_req)
    begin
      cur <= mem_rd_addr[35:3];
      left <= 4;
      n_beat <= 0;
      n_rd <= n_rd + 1;
    end
    else if (left > 0 && (!slow || g == 2'h0))
    begin
      // Beats wrap inside the line, critical doubleword first.
      mem_rd_valid <= 1'b1;
      mem_rd_data <= mem.exists(cur) ? mem[cur] : dflt(cur);
      cur[1:0] <= cur[1:0] + 2'h1;
      left <= left - 1;
      n_beat <= n_beat + 1;
    end
  end
endmodule
